/* hdl/lpc_core.sv */
// LED PWM, current scale and status register core for 36 sink channels
// ----------------------------------------------------------------
// Contract
// RQ1 - 8-bit resolution uses low duty byte only
// RQ2 - Duty low 2k-1, high 2k, scale 0x49+k
// RQ3 - Zero to update applies duty, pin and enable
// RQ4 - Current scale applies immediately on write
// RQ5 - Peak current from scale and global code
// RQ6 - One global current code scales all channels
// RQ7 - Phase delay: six groups, sixth-period offsets
// RQ8 - Clock phase: even outputs end at period end
// RQ9 - Detect mode selects short or open storage
// RQ10 - Results five bytes, top nibble reads zero
// RQ11 - Setpoint field, flag while temperature exceeds
// RQ12 - Roll-off code limits current after setpoint
// RQ13 - Host rewrites thermal fields before each read
// RQ14 - DC override forces twelve-output groups on
// RQ15 - Duty 0 to N-1; one step stays off
// RQ16 - Spread enable bit modulates PWM clock
// RQ17 - Spread range and cycle time fields
// RQ18 - Power-on and zero to reset clear all
// RQ19 - Resolution field picks 8/10/12/16 bits
// RQ20 - Software shutdown bit turns outputs off
// RQ21 - Oscillator field selects PWM counter clock
// RQ22 - Pending duty copied at next period start
// RQ23 - Shared counter compared against active duty
// ----------------------------------------------------------------
`timescale 1ns/1ps
module lpc_core
  import lpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register access strobes from the serial engine
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Pins and analog comparators
  input wire logic shutdown_pin_n_i,
  input wire logic [lpc_pkg::NCH-1:0] fault_short_i,
  input wire logic [lpc_pkg::NCH-1:0] fault_open_i,
  input wire logic [3:0] temp_above_i,
  // Drive to current sinks
  output logic [lpc_pkg::NCH-1:0] chan_on_o,
  output logic [lpc_pkg::NCH*8-1:0] chan_current_scale_o,
  output logic [7:0] global_current_code_o,
  output logic [1:0] thermal_limit_o
);
  import lpc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [NCH-1:0][7:0] duty_lo;
    logic [NCH-1:0][7:0] duty_hi;
    logic [NCH-1:0][7:0] scale;
    logic [NCH-1:0][15:0] duty_act;
    logic [7:0] global_current_code;
    logic [7:0] phase;
    logic [7:0] detect;
    logic [7:0] therm;
    logic [7:0] spread;
    logic [NCH-1:0] fault;
    logic upd_pend;
    logic [15:0] cnt;
    logic [NCH-1:0] on;
    logic [1:0] limit;
    logic [7:0] rdata;
  } lpc_core_state_t;

  lpc_core_state_t s_q;
  lpc_core_state_t s_d;

  // ----------------------------------------------------------------
  // Synchronised pins and timebase
  // ----------------------------------------------------------------
  logic pin_high;
  logic [NCH-1:0] short_sync;
  logic [NCH-1:0] open_sync;
  logic [3:0] temp_sync;
  logic tick;

  lpc_sync #(.W(1)) u_sync_pin (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i(shutdown_pin_n_i),
    .sync_o(pin_high)
  );

  lpc_sync #(.W(2 * NCH + 4)) u_sync_analog (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i({fault_short_i, fault_open_i, temp_above_i}),
    .sync_o({short_sync, open_sync, temp_sync})
  );

  // RQ21 oscillator select
  // RQ16 spread enable
  lpc_prescaler u_prescaler (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .osc_sel_i(s_q.ctrl[CTRL_OSC_LSB +: 3]),
    .spread_enable_i(s_q.spread[SPR_EN_BIT]),
    .spread_range_i(s_q.spread[SPR_RNG_LSB +: 2]),
    .spread_cycle_time_i(s_q.spread[SPR_CLT_LSB +: 2]),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    case (lpc_res_t'(res))
      RES_8: res_mask = MASK_8;
      RES_10: res_mask = MASK_10;
      RES_12: res_mask = MASK_12;
      RES_16: res_mask = MASK_16;
      default: res_mask = MASK_8;
    endcase
  endfunction

  // Group start offset in counter steps, a sixth of N per group
  function automatic logic [15:0] grp_offset(input logic [15:0] mask, input int g);
    int span;
    span = int'(mask) + 1;
    grp_offset = 16'((span * g) / NGRP);
  endfunction

  function automatic logic [7:0] read_mux(input lpc_core_state_t s, input logic [7:0] a);
    logic [8*FAULT_BYTES-1:0] fb;
    int idx;
    fb = {4'h0, s.fault};
    read_mux = RST_BYTE;
    if (a == ADDR_CTRL) begin
      read_mux = s.ctrl;
    end else if (a >= ADDR_DUTY_FIRST && a <= ADDR_DUTY_LAST) begin
      idx = int'(a - ADDR_DUTY_FIRST) / 2;
      read_mux = a[0] ? s.duty_lo[idx] : s.duty_hi[idx];
    end else if (a >= ADDR_SCALE_FIRST && a <= ADDR_SCALE_LAST) begin
      read_mux = s.scale[int'(a - ADDR_SCALE_FIRST)];
    end else if (a == ADDR_GCC) begin
      read_mux = s.global_current_code;
    end else if (a == ADDR_PHASE) begin
      read_mux = s.phase;
    end else if (a == ADDR_DETECT) begin
      read_mux = s.detect;
    end else if (a >= ADDR_FAULT_FIRST && a <= ADDR_FAULT_LAST) begin
      read_mux = fb[8 * int'(a - ADDR_FAULT_FIRST) +: 8];
    end else if (a == ADDR_THERM) begin
      read_mux = s.therm;
    end else if (a == ADDR_SPREAD) begin
      read_mux = s.spread;
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [15:0] mask;
  logic period_end;
  logic run;
  logic soft_rst;

  always_comb begin
    s_d = s_q;
    mask = res_mask(s_q.ctrl[CTRL_RES_LSB +: 2]);
    period_end = tick && (s_q.cnt >= mask);
    // RQ20 software and pin shutdown
    run = s_q.ctrl[CTRL_SSD_BIT] && pin_high;
    soft_rst = reg_wr_i && reg_addr_i == ADDR_SRST && reg_wdata_i == CMD_ZERO;

    // RQ23 shared period counter
    // RQ19 wraps at chosen resolution
    if (tick) begin
      s_d.cnt = period_end ? 16'h0000 : s_q.cnt + 16'h0001;
    end

    // RQ22 copy only at period start
    // RQ1 high byte masked off at 8 bits
    if (period_end && s_q.upd_pend) begin
      for (int k = 0; k < NCH; k++) begin
        s_d.duty_act[k] = {s_q.duty_hi[k], s_q.duty_lo[k]} & mask;
      end
      s_d.upd_pend = 1'b0;
    end

    if (reg_wr_i) begin
      // RQ2 duty and scale address map
      if (reg_addr_i == ADDR_CTRL) begin
        s_d.ctrl = reg_wdata_i & CTRL_WMASK;
      end else if (reg_addr_i >= ADDR_DUTY_FIRST && reg_addr_i <= ADDR_DUTY_LAST) begin
        if (reg_addr_i[0]) begin
          s_d.duty_lo[int'(reg_addr_i - ADDR_DUTY_FIRST) / 2] = reg_wdata_i;
        end else begin
          s_d.duty_hi[int'(reg_addr_i - ADDR_DUTY_FIRST) / 2] = reg_wdata_i;
        end
      end else if (reg_addr_i >= ADDR_SCALE_FIRST && reg_addr_i <= ADDR_SCALE_LAST) begin
        // RQ4 no update command needed
        s_d.scale[int'(reg_addr_i - ADDR_SCALE_FIRST)] = reg_wdata_i;
      end else if (reg_addr_i == ADDR_GCC) begin
        // RQ6 global code register
        s_d.global_current_code = reg_wdata_i;
      end else if (reg_addr_i == ADDR_PHASE) begin
        s_d.phase = reg_wdata_i & PHASE_WMASK;
      end else if (reg_addr_i == ADDR_DETECT) begin
        s_d.detect = reg_wdata_i & DET_WMASK;
      end else if (reg_addr_i == ADDR_THERM) begin
        s_d.therm = (reg_wdata_i & THERM_WMASK) | (s_q.therm & ~THERM_WMASK);
      end else if (reg_addr_i == ADDR_SPREAD) begin
        // RQ17 range and cycle time stored
        s_d.spread = reg_wdata_i & SPR_WMASK;
      end else if (reg_addr_i == ADDR_UPDATE && reg_wdata_i == CMD_ZERO && run) begin
        // RQ3 update armed; set wins over copy
        s_d.upd_pend = 1'b1;
      end
    end

    // RQ9 short or open results, one kind
    case (lpc_det_t'(s_q.detect[1:0]))
      DET_SHORT: s_d.fault = short_sync;
      DET_OPEN: s_d.fault = open_sync;
      default: s_d.fault = s_q.fault;
    endcase

    // RQ11 flag follows selected setpoint
    s_d.therm[THERM_FLAG_BIT] = temp_sync[s_q.therm[THERM_TS_LSB +: 2]];
    // RQ12 roll-off only past setpoint
    s_d.limit = s_q.therm[THERM_FLAG_BIT] ? s_q.therm[THERM_ROLL_LSB +: 2] : ROLL_FULL;

    for (int k = 0; k < NCH; k++) begin
      logic [15:0] lc;
      logic [15:0] d;
      logic late;
      logic pwm_on;
      lc = '0;
      d = '0;
      late = 1'b0;
      pwm_on = 1'b0;
      // RQ7 group start offsets
      lc = (s_q.cnt - (s_q.phase[PH_DELAY_BIT] ? grp_offset(mask, k / GRP_SZ) : 16'h0000)) & mask;
      d = s_q.duty_act[k] & mask;
      // RQ8 even outputs aligned to period end
      late = s_q.phase[k / GRP_SZ] && (k % 2 == 1);
      // RQ15 a single step never lights
      pwm_on = (d >= DUTY_MIN_ON) && (late ? ((mask - lc) < d) : (lc < d));
      // RQ14 DC override per twelve outputs
      s_d.on[k] = run && (s_q.spread[SPR_DC_LSB + k / DC_GRP_SZ] || pwm_on);
    end

    if (reg_rd_i) begin
      // RQ10 fault bytes, upper nibble zero
      s_d.rdata = read_mux(s_q, reg_addr_i);
    end

    // RQ18 zero to reset address clears all
    if (soft_rst) begin
      s_d = '0;
    end
  end

  // RQ18 power-on reset to zero
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from state
  // ----------------------------------------------------------------
  // RQ5 codes feed the sink scaling product
  assign chan_current_scale_o = s_q.scale;
  assign global_current_code_o = s_q.global_current_code;
  assign chan_on_o = s_q.on;
  assign thermal_limit_o = s_q.limit;
  assign reg_rdata_o = s_q.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence seq_update_cmd;
    reg_wr_i && reg_addr_i == ADDR_UPDATE && reg_wdata_i == CMD_ZERO;
  endsequence

  sequence seq_soft_reset;
    reg_wr_i && reg_addr_i == ADDR_SRST && reg_wdata_i == CMD_ZERO;
  endsequence

  a_duty_held: assert property ((!s_q.upd_pend || !period_end) && !soft_rst |=> $stable(s_q.duty_act)) // RQ22
    else $error("active duty changed without update at period start");

  a_update_gated: assert property (seq_update_cmd ##0 !run ##0 !s_q.upd_pend |=> !s_q.upd_pend) // RQ3
    else $error("update armed while shut down");

  a_update_armed: assert property (seq_update_cmd ##0 run |=> s_q.upd_pend) // RQ3
    else $error("update command not armed");

  a_scale_immediate: assert property (reg_wr_i && reg_addr_i == ADDR_SCALE_FIRST
    |=> chan_current_scale_o[7:0] == $past(reg_wdata_i)) // RQ4
    else $error("scale not applied on write");

  a_gcc_write: assert property (reg_wr_i && reg_addr_i == ADDR_GCC |=> global_current_code_o == $past(reg_wdata_i)) // RQ6
    else $error("global code not applied");

  a_res8_low_only: assert property (period_end && s_q.upd_pend && s_q.ctrl[CTRL_RES_LSB +: 2] == RES_8 && !soft_rst
    |=> s_q.duty_act[0][15:8] == 8'h00) // RQ1
    else $error("high byte used at 8-bit resolution");

  a_shutdown_off: assert property (!run |=> chan_on_o == '0) // RQ20
    else $error("output on during shutdown");

  a_dc_force: assert property (run && s_q.spread[SPR_DC_LSB] && !soft_rst |=> chan_on_o[DC_GRP_SZ-1:0] == '1) // RQ14
    else $error("DC override did not force outputs");

  a_min_duty: assert property (s_q.duty_act[0] < DUTY_MIN_ON && !s_q.spread[SPR_DC_LSB] |=> !chan_on_o[0]) // RQ15
    else $error("single step turned output on");

  a_soft_reset: assert property (seq_soft_reset |=> s_q.ctrl == '0 && global_current_code_o == '0
    && chan_current_scale_o == '0 && !s_q.upd_pend) // RQ18
    else $error("soft reset did not clear registers");

  a_fault_nibble: assert property (reg_rd_i && reg_addr_i == ADDR_FAULT_LAST |=> reg_rdata_o[7:4] == 4'h0) // RQ10
    else $error("fault upper nibble not zero");

  a_thermal_flag: assert property (!soft_rst && !(reg_wr_i && reg_addr_i == ADDR_THERM)
    |=> s_q.therm[THERM_FLAG_BIT] == $past(temp_sync[s_q.therm[THERM_TS_LSB +: 2]])) // RQ11
    else $error("thermal flag does not follow setpoint");

  a_rolloff_idle: assert property (!s_q.therm[THERM_FLAG_BIT] |=> thermal_limit_o == ROLL_FULL) // RQ12
    else $error("roll-off applied below setpoint");

endmodule

/* hdl/lpc_prescaler.sv */
// PWM counter tick generator with oscillator select and spread spectrum
`timescale 1ns/1ps
module lpc_prescaler
  import lpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Settings
  input wire logic [2:0] osc_sel_i,
  input wire logic spread_enable_i,
  input wire logic [1:0] spread_range_i,
  input wire logic [1:0] spread_cycle_time_i,
  // Tick
  output logic tick_o
);
  import lpc_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic signed [7:0] tri_pos;
    logic tri_down;
    logic [11:0] step_cnt;
    logic tick;
  } lpc_pre_state_t;

  lpc_pre_state_t s_q;
  lpc_pre_state_t s_d;

  logic signed [47:0] delta;
  logic [ACC_W:0] sum;

  // ----------------------------------------------------------------
  // Fractional divider; spread bends the increment along a triangle
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    delta = '0;
    if (spread_enable_i) begin
      delta = (signed'({24'h0, OSC_INC[osc_sel_i]}) * signed'({42'h0, SS_RANGE_Q7[spread_range_i]})
               * 48'(s_q.tri_pos)) >>> SS_SHIFT;
    end
    sum = {1'b0, s_q.acc} + (ACC_W + 1)'(48'({24'h0, OSC_INC[osc_sel_i]}) + delta);
    s_d.acc = sum[ACC_W-1:0];
    s_d.tick = sum[ACC_W];
    if (!spread_enable_i) begin
      s_d.tri_pos = '0;
      s_d.step_cnt = '0;
    end else if (s_q.step_cnt >= SS_STEP_CYC[spread_cycle_time_i]) begin
      s_d.step_cnt = '0;
      if (s_q.tri_down) begin
        s_d.tri_pos = s_q.tri_pos - 8'sh01;
        s_d.tri_down = (s_q.tri_pos != -8'sh7f);
      end else begin
        s_d.tri_pos = s_q.tri_pos + 8'sh01;
        s_d.tri_down = (s_q.tri_pos == 8'sh7e);
      end
    end else begin
      s_d.step_cnt = s_q.step_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule

/* hdl/lpc_sync.sv */
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module lpc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } lpc_sync_state_t;

  lpc_sync_state_t s_q;
  lpc_sync_state_t s_d;

  always_comb begin
    s_d.meta = async_i;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stab;

endmodule

/* include/lpc_pkg.sv */
// Shared constants and types for the LED PWM and current register core
package lpc_pkg;

  // ----------------------------------------------------------------
  // Channel organisation
  // ----------------------------------------------------------------
  localparam int NCH = 36;
  localparam int GRP_SZ = 6;
  localparam int NGRP = 6;
  localparam int DC_GRP_SZ = 12;
  localparam int FAULT_BYTES = 5;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DUTY_FIRST = 8'h01;
  localparam logic [7:0] ADDR_DUTY_LAST = 8'h48;
  localparam logic [7:0] ADDR_UPDATE = 8'h49;
  localparam logic [7:0] ADDR_SCALE_FIRST = 8'h4a;
  localparam logic [7:0] ADDR_SCALE_LAST = 8'h6d;
  localparam logic [7:0] ADDR_GCC = 8'h6e;
  localparam logic [7:0] ADDR_PHASE = 8'h70;
  localparam logic [7:0] ADDR_DETECT = 8'h71;
  localparam logic [7:0] ADDR_FAULT_FIRST = 8'h72;
  localparam logic [7:0] ADDR_FAULT_LAST = 8'h76;
  localparam logic [7:0] ADDR_THERM = 8'h77;
  localparam logic [7:0] ADDR_SPREAD = 8'h78;
  localparam logic [7:0] ADDR_SRST = 8'h7f;
  localparam logic [7:0] CMD_ZERO = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------
  localparam int CTRL_SSD_BIT = 0;
  localparam int CTRL_RES_LSB = 1;
  localparam int CTRL_OSC_LSB = 4;
  localparam int PH_DELAY_BIT = 7;
  localparam int THERM_TS_LSB = 0;
  localparam int THERM_FLAG_BIT = 4;
  localparam int THERM_ROLL_LSB = 6;
  localparam int SPR_CLT_LSB = 0;
  localparam int SPR_RNG_LSB = 2;
  localparam int SPR_EN_BIT = 4;
  localparam int SPR_DC_LSB = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h77;
  localparam logic [7:0] PHASE_WMASK = 8'hbf;
  localparam logic [7:0] DET_WMASK = 8'h03;
  localparam logic [7:0] THERM_WMASK = 8'hc3;
  localparam logic [7:0] SPR_WMASK = 8'hff;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RES_8 = 2'h0,
    RES_10 = 2'h1,
    RES_12 = 2'h2,
    RES_16 = 2'h3
  } lpc_res_t;

  typedef enum logic [1:0] {
    DET_OFF0 = 2'h0,
    DET_OFF1 = 2'h1,
    DET_SHORT = 2'h2,
    DET_OPEN = 2'h3
  } lpc_det_t;

  localparam logic [15:0] MASK_8 = 16'h00ff;
  localparam logic [15:0] MASK_10 = 16'h03ff;
  localparam logic [15:0] MASK_12 = 16'h0fff;
  localparam logic [15:0] MASK_16 = 16'hffff;
  localparam logic [15:0] DUTY_MIN_ON = 16'h0002;
  localparam logic [1:0] ROLL_FULL = 2'h0;

  // ----------------------------------------------------------------
  // Timebase: phase accumulator increments per oscillator code
  // ----------------------------------------------------------------
  localparam longint CLK_KHZ = 250000;
  localparam int CLK_MHZ = 250;
  localparam int ACC_W = 24;
  localparam logic [23:0] OSC_INC [8] = '{
    24'((longint'(16000) << ACC_W) / CLK_KHZ),
    24'((longint'(8000) << ACC_W) / CLK_KHZ),
    24'((longint'(1000) << ACC_W) / CLK_KHZ),
    24'((longint'(500) << ACC_W) / CLK_KHZ),
    24'((longint'(250) << ACC_W) / CLK_KHZ),
    24'((longint'(125) << ACC_W) / CLK_KHZ),
    24'((longint'(62) << ACC_W) / CLK_KHZ),
    24'((longint'(31) << ACC_W) / CLK_KHZ)
  };

  // Spread: triangle of SS_STEPS steps per modulation cycle
  localparam int SS_STEPS = 512;
  localparam int SS_CYCLE_US [4] = '{1980, 1200, 820, 660};
  localparam logic [11:0] SS_STEP_CYC [4] = '{
    12'(SS_CYCLE_US[0] * CLK_MHZ / SS_STEPS),
    12'(SS_CYCLE_US[1] * CLK_MHZ / SS_STEPS),
    12'(SS_CYCLE_US[2] * CLK_MHZ / SS_STEPS),
    12'(SS_CYCLE_US[3] * CLK_MHZ / SS_STEPS)
  };
  // Range in 1/128 units: 5, 15, 24, 34 percent
  localparam logic [5:0] SS_RANGE_Q7 [4] = '{6'h06, 6'h13, 6'h1f, 6'h2c};
  localparam int SS_SHIFT = 14;

endpackage

/* tb/lpc_host_model.sv */
// Host side model issuing register access strobes
`timescale 1ns/1ps
module lpc_host_model
  import lpc_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Register strobes
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // Released fields show inverted values so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
  task automatic therm(input logic [7:0] cfg, output logic [7:0] d);
    wr(ADDR_THERM, cfg);
    repeat (2) @(posedge clk_sys_i);
    rd(ADDR_THERM, d);
  endtask
endmodule

/* tb/test_led_pwm_current_register_core.sv */
// Self-checking bench for the LED PWM and current register core
`timescale 1ns/1ps
module test_led_pwm_current_register_core;
  import lpc_pkg::*;
  logic clk_sys_i, sys_rst_i, shutdown_pin_n_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, global_current_code_o, v;
  logic [NCH-1:0] fault_short_i, fault_open_i, chan_on_o;
  logic [3:0] temp_above_i;
  logic [NCH*8-1:0] chan_current_scale_o;
  logic [1:0] thermal_limit_o;
  logic [39:0] held;
  logic [7:0] mdl [128];
  int failures, compares, cyc, seed, ovl;
  int onc [NCH];

  lpc_core uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .shutdown_pin_n_i(shutdown_pin_n_i), .fault_short_i(fault_short_i), .fault_open_i(fault_open_i),
    .temp_above_i(temp_above_i), .chan_on_o(chan_on_o), .chan_current_scale_o(chan_current_scale_o),
    .global_current_code_o(global_current_code_o), .thermal_limit_o(thermal_limit_o));
  lpc_host_model host (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Ceiling sized for about 77000 cycles of traffic
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 100000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Register model and access
  // ----------------------------------------------------------------
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    #1;
    if (a == ADDR_SRST && d == RST_BYTE) mdl = '{default: 8'h00};
    else if (a == ADDR_CTRL) mdl[a] = d & CTRL_WMASK;
    else if (a == ADDR_PHASE) mdl[a] = d & PHASE_WMASK;
    else if (a == ADDR_DETECT) mdl[a] = d & DET_WMASK;
    else if (a == ADDR_THERM) mdl[a] = d & THERM_WMASK;
    else if (a == ADDR_GCC || a == ADDR_SPREAD || (a >= ADDR_DUTY_FIRST && a <= ADDR_DUTY_LAST)) mdl[a] = d;
    else if (a >= ADDR_SCALE_FIRST && a <= ADDR_SCALE_LAST) mdl[a] = d;
  endtask
  task automatic rc(input logic [7:0] a);
    // thermal fields rewritten before a read
    if (a == ADDR_THERM) host.therm(mdl[a], v);
    else host.rd(a, v);
    chk(v, mdl[a]);
  endtask
  task automatic rall();
    for (int a = 0; a < 128; a++) rc(8'(a));
  endtask
  // Counts on-cycles per output, and cycles where outputs p and q are both on
  task automatic run(input int n, input int p = 0, input int q = 0);
    onc = '{default: 0};
    ovl = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
      for (int i = 0; i < NCH; i++) onc[i] += chan_on_o[i];
      ovl += chan_on_o[p] & chan_on_o[q];
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hb385;
    sys_rst_i = 1'b1;
    shutdown_pin_n_i = 1'b1;
    fault_short_i = '0;
    fault_open_i = '0;
    temp_above_i = 4'h0;
    mdl = '{default: 8'h00};
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rall();
    for (int a = 0; a < 127; a++) w(8'(a), 8'($random(seed)));
    rall();
    for (int k = 0; k < NCH; k++) chk(chan_current_scale_o[8*k+:8], mdl[ADDR_SCALE_FIRST+k]);
    chk(global_current_code_o, mdl[ADDR_GCC]);
    w(ADDR_SRST, RST_BYTE);
    chk(|chan_current_scale_o, 1'b0);
    rall();
    w(ADDR_GCC, 8'h5a);
    w(ADDR_SRST, 8'h01);
    rc(ADDR_GCC);
    // Detect modes short, open, then off holding the last result
    for (int m = 2; m < 5; m++) begin
      @(posedge clk_sys_i);
      fault_open_i <= NCH'({$random(seed), $random(seed)});
      fault_short_i <= NCH'({$random(seed), $random(seed)});
      w(ADDR_DETECT, 8'(m[1:0]));
      repeat (4) @(posedge clk_sys_i);
      if (m < 4) held = {4'h0, (m == 2) ? fault_short_i : fault_open_i};
      for (int b = 0; b < FAULT_BYTES; b++) begin
        host.rd(ADDR_FAULT_FIRST + 8'(b), v);
        chk(v, held[8*b+:8]);
      end
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      temp_above_i <= 4'($random(seed));
      v = {i[3:2], 4'h0, i[1:0]};
      mdl[ADDR_THERM] = v;
      host.therm(v, v);
      chk(v, mdl[ADDR_THERM] | {3'h0, temp_above_i[i[1:0]], 4'h0});
      chk(thermal_limit_o, temp_above_i[i[1:0]] ? i[3:2] : 2'h0);
    end
    // Duty traffic, 8-bit period is about 4000 clocks
    w(8'h01, 8'h00);
    w(8'h02, 8'hff);
    w(8'h03, 8'h80);
    w(8'h05, 8'h01);
    w(8'h07, 8'hff);
    w(8'h0d, 8'h80);
    // Update refused while in software shutdown
    w(ADDR_UPDATE, CMD_ZERO);
    w(ADDR_CTRL, 8'h01);
    run(6000);
    for (int i = 0; i < NCH; i++) chk(onc[i], 0);
    w(ADDR_UPDATE, CMD_ZERO);
    repeat (4500) @(posedge clk_sys_i);
    run(8000);
    chk(onc[0], 0);
    chk(onc[2], 0);
    chk(onc[1] > 3900 && onc[1] < 4100, 1);
    chk(onc[3] > 7900, 1);
    w(8'h03, 8'h00);
    w(ADDR_UPDATE, 8'h01);
    // Group 2 trails group 1 by 42 of 256 steps
    w(ADDR_PHASE, 8'h80);
    repeat (4500) @(posedge clk_sys_i);
    run(4000, 1, 6);
    chk(onc[1] > 1900, 1);
    chk(ovl > 1250 && ovl < 1450, 1);
    // Ten-bit duty 0x300 of 1024, period about 16000 clocks
    w(ADDR_CTRL, 8'h03);
    w(ADDR_UPDATE, CMD_ZERO);
    repeat (16500) @(posedge clk_sys_i);
    run(16000);
    chk(onc[0] > 11900 && onc[0] < 12100, 1);
    // Output 4 moves its pulse to the period end
    w(ADDR_PHASE, 8'h81);
    run(16000, 0, 3);
    chk(ovl, 0);
    chk(onc[3] > 3900 && onc[3] < 4100, 1);
    w(ADDR_SPREAD, 8'h20);
    repeat (10) @(posedge clk_sys_i);
    run(100);
    chk(onc[0], 100);
    chk(onc[12], 0);
    w(ADDR_CTRL, 8'h02);
    repeat (4) @(posedge clk_sys_i);
    run(100);
    chk(onc[0], 0);
    test_done();
  end
endmodule
